/* core/bsb_addr_map.sv */
// module: maps an 8-bit operand address onto the 12-bit data space
`timescale 1ns/1ns
module bsb_addr_map
    import bsb_pkg::*;
(
    // operand
    input wire logic [7:0] file_addr_in,
    input wire logic access_sel_in,
    input wire logic [3:0] bank_select_register_in,
    // result
    output logic [ADDR_W-1:0] data_addr_out
);
    // access=0 lands in the shared low bank whatever the bank register holds
    always_comb begin
        if (access_sel_in) begin
            data_addr_out = {bank_select_register_in, file_addr_in};
        end else begin
            data_addr_out = {BANK_LOW, file_addr_in};
        end
    end
endmodule // bsb_addr_map

/* core/bsb_exec.sv */
// module: executes jump, bit force one and bit test skip instructions
// ==========================================================
// Overview of operation
// - relative jump takes two cycles, second idle
// - force one sets chosen bit, others kept
// - access bit zero selects shared low bank
// - access bit one uses bank register bank
// - jump is five-bit opcode, eleven-bit offset
// - target is jump address plus two plus 2n
`timescale 1ns/1ns
module bsb_exec
    import bsb_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // instruction stream, one word per cycle
    input wire logic [15:0] instr_in,
    input wire logic next_is_two_word_in,
    input wire logic [3:0] bank_select_register_in,
    // data memory read port, same-cycle data
    input wire logic [7:0] rd_data_in,
    output logic [ADDR_W-1:0] mem_addr_out,
    // data memory write port
    output logic wr_en_out,
    output logic [7:0] wr_data_out,
    output logic [ADDR_W-1:0] wr_addr_out,
    // core status
    output logic [PC_W-1:0] pc_out,
    output logic idle_cycle_out
);
    // ==========================================================
    // decode
    function automatic logic is_bit_op(input logic [15:0] w, input logic [3:0] op);
        is_bit_op = (w[INSTR_W-1:OP_LO] == op);
    endfunction

    bsb_state_e state;
    bsb_state_e next_state;
    logic [PC_W-1:0] next_pc;
    logic next_wr_en;
    logic [7:0] next_wr_data;
    logic [ADDR_W-1:0] next_wr_addr;
    logic [7:0] bit_mask;
    logic bit_val;
    logic [PC_W-1:0] jump_ofs;
    logic do_jump;
    logic do_force;
    logic do_skip;

    bsb_addr_map u_map (
        .file_addr_in(instr_in[FILE_W-1:0]),
        .access_sel_in(instr_in[ACCESS_POS]),
        .bank_select_register_in(bank_select_register_in),
        .data_addr_out(mem_addr_out)
    );

    always_comb begin
        bit_mask = BYTE_ONE << instr_in[BIT_HI:BIT_LO];
        bit_val = |(rd_data_in & bit_mask);
        jump_ofs = PC_W'({{(PC_W-OFS_W-1){instr_in[OFS_W-1]}}, instr_in[OFS_W-1:0], 1'b0});
        do_jump = (state == BSB_EXEC) && (instr_in[INSTR_W-1:JUMP_OP_LO] == OP_JUMP);
        do_force = (state == BSB_EXEC) && is_bit_op(instr_in, OP_FORCE_ONE);
        do_skip = (state == BSB_EXEC)
            && ((is_bit_op(instr_in, OP_SKIP_ZERO) && !bit_val)
            || (is_bit_op(instr_in, OP_SKIP_ONE) && bit_val));
    end

    // ==========================================================
    // sequencing; pc holds the address of the word in execute
    always_comb begin
        next_state = BSB_EXEC;
        next_pc = pc_out + PC_STEP;
        next_wr_en = 1'b0;
        next_wr_data = wr_data_out;
        next_wr_addr = wr_addr_out;
        case (state)
            BSB_EXEC: begin
                if (do_jump) begin
                    next_pc = pc_out + PC_STEP + jump_ofs;
                    next_state = BSB_FLUSH;
                end else if (do_skip) begin
                    // the fetched word is thrown away, not executed
                    next_state = next_is_two_word_in ? BSB_FLUSH2 : BSB_FLUSH;
                end else if (do_force) begin
                    next_wr_en = 1'b1;
                    next_wr_data = rd_data_in | bit_mask;
                    next_wr_addr = mem_addr_out;
                end
            end
            BSB_FLUSH2: begin
                next_state = BSB_FLUSH;
            end
            // every flush state drains back to execute, so none can stick
            default: begin
                next_state = BSB_EXEC;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= BSB_EXEC;
            pc_out <= PC_RESET;
            wr_en_out <= 1'b0;
            wr_data_out <= BYTE_ZERO;
            wr_addr_out <= '0;
        end else begin
            state <= next_state;
            pc_out <= next_pc;
            wr_en_out <= next_wr_en;
            wr_data_out <= next_wr_data;
            wr_addr_out <= next_wr_addr;
        end
    end

    // idle cycles write nothing and do not advance the discarded word's effects
    assign idle_cycle_out = (state != BSB_EXEC);

    // ==========================================================
    // checks
    // skip codes differ only in the low opcode bit, which is the level that does not skip
    property p_jump_two;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        do_jump |=> idle_cycle_out ##1 !idle_cycle_out;
    endproperty
    a_jump_two: assert property (p_jump_two) else $error("jump not two cycles");

    property p_jump_target;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        do_jump |=> pc_out == $past(pc_out) + PC_STEP + $past(jump_ofs);
    endproperty
    a_jump_target: assert property (p_jump_target) else $error("bad jump target");

    property p_force;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        do_force |=> wr_en_out && wr_data_out == ($past(rd_data_in) | $past(bit_mask));
    endproperty
    a_force: assert property (p_force) else $error("bit force wrong");

    property p_force_bit;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        wr_en_out |-> (wr_data_out & $past(bit_mask)) != BYTE_ZERO;
    endproperty
    a_force_bit: assert property (p_force_bit) else $error("bit not set");

    property p_low_bank;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        !instr_in[ACCESS_POS] |-> mem_addr_out[ADDR_W-1:FILE_W] == BANK_LOW;
    endproperty
    a_low_bank: assert property (p_low_bank) else $error("low bank not used");

    property p_bank_reg;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        instr_in[ACCESS_POS] |-> mem_addr_out[ADDR_W-1:FILE_W] == bank_select_register_in;
    endproperty
    a_bank_reg: assert property (p_bank_reg) else $error("bank register ignored");

    property p_skip_long;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        do_skip && next_is_two_word_in |=> idle_cycle_out [*2] ##1 !idle_cycle_out;
    endproperty
    a_skip_long: assert property (p_skip_long) else $error("long skip length");

    property p_skip_short;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        do_skip && !next_is_two_word_in |=> idle_cycle_out ##1 !idle_cycle_out;
    endproperty
    a_skip_short: assert property (p_skip_short) else $error("short skip length");

    property p_idle_quiet;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        idle_cycle_out |=> !wr_en_out;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("write in idle cycle");

    property p_idle_step;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        idle_cycle_out |=> pc_out == $past(pc_out) + PC_STEP;
    endproperty
    a_idle_step: assert property (p_idle_step) else $error("idle cycle acted on word");

    property p_force_keep;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        do_force |=> (wr_data_out & ~$past(bit_mask))
            == ($past(rd_data_in) & ~$past(bit_mask));
    endproperty
    a_force_keep: assert property (p_force_keep) else $error("other bits changed");

    property p_force_addr;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        do_force |=> wr_addr_out == $past(mem_addr_out);
    endproperty
    a_force_addr: assert property (p_force_addr) else $error("write address wrong");

    property p_skip_taken;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        !idle_cycle_out
            && (is_bit_op(instr_in, OP_SKIP_ZERO) || is_bit_op(instr_in, OP_SKIP_ONE))
            && (rd_data_in[instr_in[BIT_HI:BIT_LO]] != instr_in[OP_LO])
            |=> idle_cycle_out;
    endproperty
    a_skip_taken: assert property (p_skip_taken) else $error("skip not taken");

    property p_no_skip;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        !idle_cycle_out
            && (is_bit_op(instr_in, OP_SKIP_ZERO) || is_bit_op(instr_in, OP_SKIP_ONE))
            && (rd_data_in[instr_in[BIT_HI:BIT_LO]] == instr_in[OP_LO])
            |=> !idle_cycle_out;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("skip taken without cause");

    property p_other_step;
        @(posedge ref_clk_in) disable iff (!reset_n_in)
        !idle_cycle_out && instr_in[INSTR_W-1:JUMP_OP_LO] != OP_JUMP
            |=> pc_out == $past(pc_out) + PC_STEP;
    endproperty
    a_other_step: assert property (p_other_step) else $error("pc moved without jump");

    c_jump: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in) do_jump);
    c_force: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in) do_force);
    c_skip: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in) do_skip);
    c_skip2: cover property (@(posedge ref_clk_in) disable iff (!reset_n_in)
        do_skip && next_is_two_word_in);
endmodule // bsb_exec

/* pkg/bsb_pkg.sv */
// package: encodings, widths and timing for the bit-set / branch / skip executor
package bsb_pkg;
    localparam int PC_W = 21;
    localparam int ADDR_W = 12;
    localparam int OFS_W = 11;
    localparam logic [4:0] OP_JUMP = 5'h1A;
    localparam logic [3:0] OP_FORCE_ONE = 4'h8;
    localparam logic [3:0] OP_SKIP_ZERO = 4'hB;
    localparam logic [3:0] OP_SKIP_ONE = 4'hA;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [3:0] BANK_LOW = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [1:0] CYC_JUMP = 2'h2;
    localparam logic [1:0] CYC_SKIP = 2'h2;
    localparam logic [1:0] CYC_SKIP_LONG = 2'h3;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [15:0] NOP_WORD = 16'h0000;
    // instruction word field positions
    localparam int INSTR_W = 16;
    localparam int OP_LO = 12;
    localparam int JUMP_OP_LO = 11;
    localparam int BIT_HI = 11;
    localparam int BIT_LO = 9;
    localparam int ACCESS_POS = 8;
    localparam int FILE_W = 8;
    typedef enum logic [1:0] {BSB_EXEC, BSB_FLUSH, BSB_FLUSH2} bsb_state_e;
endpackage

/* test/bit_set_branch_exec_tb.sv */
// testbench: jump, bit force one and bit test skip behaviour
`timescale 1ns/1ns
module bit_set_branch_exec_tb;
    import bsb_pkg::*;
    // ====
    // signals
    logic ref_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [15:0] instr_in = 16'h0000;
    logic two_w = 1'b0;
    logic [3:0] bank = 4'h5;
    logic [7:0] rd_data_in = 8'h00;
    logic [ADDR_W-1:0] mem_addr;
    logic [ADDR_W-1:0] wr_addr;
    logic wr_en;
    logic idle;
    logic [7:0] wr_data;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] exp_pc;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    bsb_exec dut_u (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .instr_in(instr_in),
        .next_is_two_word_in(two_w), .bank_select_register_in(bank), .rd_data_in(rd_data_in),
        .mem_addr_out(mem_addr), .wr_en_out(wr_en), .wr_data_out(wr_data),
        .wr_addr_out(wr_addr), .pc_out(pc), .idle_cycle_out(idle));
    always #5 ref_clk_in = ~ref_clk_in;
    // whole run needs well under a hundred cycles
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            stop_test();
        end
    end
    task stop_test;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task chk_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task chk_vec(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // inputs always move 1 ns after the edge
    task nxt;
        @(posedge ref_clk_in);
        #1;
        exp_pc = exp_pc + PC_STEP;
        chk_vec(pc, exp_pc, "pc step");
    endtask
    task t_jump(input logic [10:0] ofs);
        instr_in = {OP_JUMP, ofs};
        @(posedge ref_clk_in);
        #1;
        exp_pc = exp_pc + PC_STEP + {{9{ofs[10]}}, ofs, 1'b0};
        chk_vec(pc, exp_pc, "jump target");
        chk_bit(idle, 1'b1, "jump idle");
        instr_in = 16'h8F00;
        nxt();
        chk_bit(idle, 1'b0, "jump idle ends");
        chk_bit(wr_en, 1'b0, "discarded word wrote");
    endtask
    task t_force(input logic a, input logic [2:0] b, input logic [7:0] f, input logic [7:0] old);
        logic [ADDR_W-1:0] ea;
        ea = {a ? bank : BANK_LOW, f};
        instr_in = {OP_FORCE_ONE, b, a, f};
        rd_data_in = old;
        #1 chk_vec(PC_W'(mem_addr), PC_W'(ea), "bank map");
        nxt();
        instr_in = NOP_WORD;
        chk_bit(wr_en, 1'b1, "write pulse");
        chk_vec(PC_W'(wr_data), PC_W'(old | (BYTE_ONE << b)), "forced byte");
        chk_vec(PC_W'(wr_addr), PC_W'(ea), "write address");
        nxt();
        chk_bit(wr_en, 1'b0, "pulse one cycle");
    endtask
    task t_skip(input logic [3:0] op, input logic [7:0] old, input logic tw, input int idles);
        instr_in = {op, 3'h3, 1'b1, 8'h34};
        rd_data_in = old;
        two_w = tw;
        nxt();
        // a bit force word follows; it may run only when nothing is skipped
        instr_in = 16'h8F00;
        for (int i = 0; i <= idles; i++) begin
            chk_bit(idle, i < idles, "skip idle");
            chk_bit(wr_en, 1'b0, "skipped word wrote");
            if (i < idles) nxt();
        end
        if (idles == 0) begin
            nxt();
            chk_bit(wr_en, 1'b1, "word after test lost");
        end
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_in);
        #1 reset_n_in = 1'b1;
        exp_pc = PC_RESET;
        chk_vec(pc, PC_RESET, "reset pc");
        t_jump(11'h400);
        t_jump(11'h3FF);
        t_force(1'b0, 3'h7, 8'h9C, 8'h0A);
        t_force(1'b1, 3'h0, 8'h12, 8'hFE);
        t_skip(OP_SKIP_ZERO, 8'hF7, 1'b0, 1);
        t_skip(OP_SKIP_ZERO, 8'hF7, 1'b1, 2);
        t_skip(OP_SKIP_ZERO, 8'h08, 1'b1, 0);
        t_skip(OP_SKIP_ONE, 8'h08, 1'b1, 2);
        t_skip(OP_SKIP_ONE, 8'hF7, 1'b0, 0);
        stop_test();
    end
endmodule // bit_set_branch_exec_tb
